/* File: hdl/t1fa_frame_aligner.sv */
// Purpose: T1 frame aligner configuration, lock control and event reporting
// Assumes: Search datapath on sys_clk presents framing bits and candidates
// Notes: Register bus address equals the register index
`timescale 1ns/10ps
module t1fa_frame_aligner (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire t1fa_pkg::t1fa_bus_in_type bus_in,
  input wire t1fa_pkg::t1fa_search_in_type search_in,
  output logic [7:0] rd_data,
  output logic irq_out_n,
  output logic frame_locked_state,
  output logic mimic_present,
  output logic fdl_bit,
  output logic fdl_valid
);
  import t1fa_pkg::*;

  t1fa_state_type st;
  t1fa_state_type next_st;
  t1fa_evt_type ev;
  t1fa_fmt_type fmt;
  logic rd_sts;
  logic lock_now;
  logic [2:0] lock_pos;
  logic [`T1FA_HIST_LEN-1:0] hist_new;
  logic [2:0] sfe_sum;
  logic fbit_err;

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    return idx;
  endfunction

  function automatic logic [3:0] ones_in(input logic [`T1FA_HIST_LEN-1:0] hist,
                                         input logic [3:0] span);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < `T1FA_HIST_LEN; i++)
    begin
      if (4'(i) < span && hist[i])
      begin
        n = n + 4'h1;
      end
    end
    return n;
  endfunction

  function automatic logic [3:0] popcnt(input logic [`T1FA_NCAND-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < `T1FA_NCAND; i++)
    begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction

  function automatic logic [2:0] first_idx(input logic [`T1FA_NCAND-1:0] v);
    logic [2:0] p;
    p = 3'h0;
    for (int i = `T1FA_NCAND - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  function automatic t1fa_fmt_type decode_fmt(input t1fa_cfg_type c);
    logic [1:0] fms;
    fms = {c.frame_mode_sel_hi, c.frame_mode_sel_lo};
    if (c.esf_sel)
    begin
      return FMT_ESF;
    end
    case (fms)
      `T1FA_FMS_SF: return FMT_SF;
      `T1FA_FMS_SLC: return FMT_SLC;
      default: return FMT_T1DM;
    endcase
  endfunction

  function automatic logic [3:0] lof_span(input t1fa_cfg_type c, input t1fa_fmt_type f);
    if (f == FMT_T1DM)
    begin
      return `T1FA_SPAN_T1DM;
    end
    case (c.out_of_frame_ratio_sel)
      `T1FA_RATIO_2OF5: return `T1FA_SPAN_2OF5;
      `T1FA_RATIO_2OF6: return `T1FA_SPAN_2OF6;
      default: return `T1FA_SPAN_2OF4;
    endcase
  endfunction

  function automatic logic fdl_take(input t1fa_cfg_type c, input logic [4:0] fnum);
    case ({c.frame_mode_sel_hi, c.frame_mode_sel_lo})
      `T1FA_FDL_FULL: return fnum[0];
      `T1FA_FDL_HALF_A: return fnum[1:0] == `T1FA_FDL_PHASE_A;
      `T1FA_FDL_HALF_B: return fnum[1:0] == `T1FA_FDL_PHASE_B;
      default: return 1'b0;
    endcase
  endfunction

  always_comb
  begin
    next_st = st;
    ev = '0;
    fmt = decode_fmt(st.cfg);
    rd_sts = bus_in.rd && bus_in.addr == byte_addr(`T1FA_STS_IDX);
    lock_now = 1'b0;
    lock_pos = 3'h0;
    hist_new = {st.hist[`T1FA_HIST_LEN-2:0], search_in.fbit_error};
    fbit_err = search_in.fbit_strobe && search_in.fbit_error;
    sfe_sum = 3'(st.sfe_cnt) + 3'(fbit_err)
      + 3'(fmt == FMT_T1DM && search_in.sync_err);

    // Mimic detection from candidate set
    if (search_in.cand_valid)
    begin
      next_st.mimic = popcnt(search_in.cand_match) > 4'h1;
      ev.mimic_change_flag = next_st.mimic != st.mimic;
    end

    case (st.align)
      ALIGN_SEARCH:
      begin
        if (search_in.cand_valid)
        begin
          if (fmt == FMT_ESF && st.cfg.esf_search_algo_sel)
          begin
            lock_now = |(search_in.cand_match & search_in.cand_crc_ok);
            lock_pos = first_idx(search_in.cand_match & search_in.cand_crc_ok);
          end
          else
          begin
            lock_now = popcnt(search_in.cand_match) == 4'h1;
            lock_pos = first_idx(search_in.cand_match);
          end
        end
        if (lock_now)
        begin
          next_st.align = ALIGN_LOCKED;
          ev.aligned_change_flag = 1'b1;
          ev.align_change_flag = st.had_pos && lock_pos != st.pos;
          next_st.pos = lock_pos;
          next_st.had_pos = 1'b1;
          next_st.hist = '0;
          next_st.sfe_cnt = '0;
        end
      end
      ALIGN_LOCKED:
      begin
        ev.framing_error_flag = fbit_err;
        case (fmt)
          FMT_ESF: ev.bit_error_event_flag = search_in.crc_err;
          FMT_T1DM: ev.bit_error_event_flag = fbit_err || search_in.sync_err;
          default: ev.bit_error_event_flag = fbit_err;
        endcase
        ev.severe_framing_flag = 3'(st.sfe_cnt) < `T1FA_SFE_THR
          && sfe_sum >= `T1FA_SFE_THR;
        if (search_in.sf_end)
        begin
          next_st.sfe_cnt = '0;
        end
        else
        begin
          next_st.sfe_cnt = sfe_sum >= `T1FA_SFE_THR ? 2'(`T1FA_SFE_THR) : sfe_sum[1:0];
        end
        if (search_in.fbit_strobe)
        begin
          next_st.hist = hist_new;
          if (ones_in(hist_new, lof_span(st.cfg, fmt)) >=
              (fmt == FMT_T1DM ? `T1FA_THR_T1DM : `T1FA_THR_STD))
          begin
            next_st.align = ALIGN_SEARCH;
            ev.aligned_change_flag = 1'b1;
            next_st.hist = '0;
          end
        end
      end
      default:
      begin
        next_st.align = ALIGN_SEARCH;
      end
    endcase

    // Facility data link extraction
    next_st.fdl_valid = st.align == ALIGN_LOCKED && fmt == FMT_ESF
      && search_in.fbit_strobe && fdl_take(st.cfg, search_in.frame_num);
    if (next_st.fdl_valid)
    begin
      next_st.fdl_bit = search_in.fbit_data;
    end

    // Register writes
    if (bus_in.wr && bus_in.addr == byte_addr(`T1FA_CFG_IDX))
    begin
      next_st.cfg = t1fa_cfg_type'(bus_in.wr_data);
      next_st.cfg.unused = '0;
    end
    if (bus_in.wr && bus_in.addr == byte_addr(`T1FA_IEN_IDX))
    begin
      next_st.ien = t1fa_ien_type'(bus_in.wr_data);
      next_st.ien.unused = 1'b0;
    end

    // Register reads, data in following cycle only
    next_st.rd_data = `T1FA_RD_IDLE;
    if (bus_in.rd)
    begin
      if (bus_in.addr == byte_addr(`T1FA_CFG_IDX))
      begin
        next_st.rd_data = st.cfg;
      end
      else if (bus_in.addr == byte_addr(`T1FA_IEN_IDX))
      begin
        next_st.rd_data = st.ien;
      end
      else if (rd_sts)
      begin
        next_st.rd_data = {st.flags, st.mimic, st.align == ALIGN_LOCKED};
      end
    end

    // Latched flags, new event beats the read clear
    next_st.flags = (rd_sts ? t1fa_evt_type'('0) : st.flags) | ev;
    next_st.irq_n = ~|(next_st.flags & next_st.ien[5:0]);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.cfg <= `T1FA_CFG_RST;
      st.ien <= `T1FA_IEN_RST;
      st.irq_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign irq_out_n = st.irq_n;
  assign frame_locked_state = st.align;
  assign mimic_present = st.mimic;
  assign fdl_bit = st.fdl_bit;
  assign fdl_valid = st.fdl_valid;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_lof_two_four: assert property (
    st.align == ALIGN_LOCKED && fmt != FMT_T1DM
    && st.cfg.out_of_frame_ratio_sel == `T1FA_RATIO_2OF4 && fbit_err
    && ones_in(st.hist, 4'h3) == 4'h1 |=> !frame_locked_state)
    else $error("lock kept after 2 of 4 framing errors");

  a_t1dm_three_kept: assert property (
    st.align == ALIGN_LOCKED && fmt == FMT_T1DM && fbit_err
    && ones_in(st.hist, 4'hb) == 4'h2 |=> frame_locked_state)
    else $error("T1DM lock lost at 3 of 12 errors");

  a_esf_mimic_hold: assert property (
    st.align == ALIGN_SEARCH && fmt == FMT_ESF && !st.cfg.esf_search_algo_sel
    && search_in.cand_valid && popcnt(search_in.cand_match) > 4'h1
    |=> !frame_locked_state)
    else $error("locked while mimics present");

  a_esf_crc_lock: assert property (
    st.align == ALIGN_SEARCH && fmt == FMT_ESF && st.cfg.esf_search_algo_sel
    && search_in.cand_valid && |(search_in.cand_match & search_in.cand_crc_ok)
    |=> frame_locked_state)
    else $error("no lock on CRC confirmed candidate");

  a_fdl_full_rate: assert property (
    frame_locked_state && st.cfg.esf_sel && !st.cfg.frame_mode_sel_hi
    && !st.cfg.frame_mode_sel_lo && search_in.fbit_strobe
    |=> fdl_valid == $past(search_in.frame_num[0]))
    else $error("full rate link bit selection wrong");

  a_fdl_half_rate: assert property (
    frame_locked_state && st.cfg.esf_sel && !st.cfg.frame_mode_sel_hi
    && st.cfg.frame_mode_sel_lo && search_in.fbit_strobe
    |=> fdl_valid == ($past(search_in.frame_num[1:0]) == `T1FA_FDL_PHASE_A))
    else $error("half rate link bit selection wrong");

  a_mimic_change: assert property (
    $changed(mimic_present) |-> st.flags.mimic_change_flag)
    else $error("mimic change not latched");

  a_lock_change: assert property (
    $changed(frame_locked_state) |-> st.flags.aligned_change_flag)
    else $error("lock change not latched");

  a_status_read: assert property (
    rd_sts |=> rd_data == {$past(st.flags), $past(mimic_present),
                           $past(frame_locked_state)})
    else $error("status read data wrong");

  a_read_clears: assert property (
    rd_sts && ev == '0 |=> st.flags == '0 ##1 (rd_data == `T1FA_RD_IDLE || $past(bus_in.rd)))
    else $error("status read did not clear flags");

  a_irq_gate: assert property (
    irq_out_n == !(|(st.flags & st.ien[5:0])))
    else $error("interrupt output disagrees with flags");

  a_frame_err_flag: assert property (
    st.align == ALIGN_LOCKED && fbit_err |=> st.flags.framing_error_flag)
    else $error("framing error not latched");

  a_severe_flag: assert property (
    st.align == ALIGN_LOCKED && st.sfe_cnt == 2'h1 && fbit_err
    |=> st.flags.severe_framing_flag)
    else $error("second framing error not flagged severe");

  a_realign_flag: assert property (
    st.align == ALIGN_SEARCH && lock_now && st.had_pos && lock_pos != st.pos
    |=> st.flags.align_change_flag)
    else $error("new alignment position not flagged");

  a_crc_bit_error: assert property (
    st.align == ALIGN_LOCKED && fmt == FMT_ESF && search_in.crc_err
    |=> st.flags.bit_error_event_flag)
    else $error("CRC mismatch not flagged");

  a_sync_bit_error: assert property (
    st.align == ALIGN_LOCKED && fmt == FMT_T1DM && search_in.sync_err
    |=> st.flags.bit_error_event_flag)
    else $error("sync word error not flagged");

  a_t1dm_ratio_kept: assert property (
    st.align == ALIGN_LOCKED && fmt == FMT_T1DM && fbit_err
    && ones_in(st.hist, 4'h3) == 4'h1 && ones_in(st.hist, 4'hb) == 4'h1
    |=> frame_locked_state)
    else $error("T1DM lock lost at 2 of 4 errors");

  a_fdl_half_b: assert property (
    frame_locked_state && st.cfg.esf_sel && st.cfg.frame_mode_sel_hi
    && !st.cfg.frame_mode_sel_lo && search_in.fbit_strobe
    |=> fdl_valid == ($past(search_in.frame_num[1:0]) == `T1FA_FDL_PHASE_B))
    else $error("second half rate subset wrong");

  a_fdl_needs_lock: assert property (
    !frame_locked_state |=> !fdl_valid)
    else $error("link bit while out of frame");

  c_lock_gain: cover property ($rose(frame_locked_state));
  c_lock_loss: cover property ($fell(frame_locked_state));
  c_realign: cover property ($rose(st.flags.align_change_flag));
  c_severe: cover property ($rose(st.flags.severe_framing_flag));
  c_mimic: cover property ($rose(mimic_present));

endmodule // t1fa_frame_aligner

/* File: hdl/t1fa_consts.svh */
// Purpose: Constants of the T1 frame aligner control block
// Assumes: Included by the package; the aligner module uses its macros without including it
// Notes: Register address on the bus equals the register index
`ifndef T1FA_CONSTS_SVH
`define T1FA_CONSTS_SVH

`define T1FA_CFG_IDX 8'h20
`define T1FA_IEN_IDX 8'h21
`define T1FA_STS_IDX 8'h22
`define T1FA_CFG_RST 8'h00
`define T1FA_IEN_RST 8'h00
`define T1FA_RD_IDLE 8'h00

`define T1FA_RATIO_2OF4 2'h0
`define T1FA_RATIO_2OF5 2'h1
`define T1FA_RATIO_2OF6 2'h2
`define T1FA_SPAN_2OF4 4'h4
`define T1FA_SPAN_2OF5 4'h5
`define T1FA_SPAN_2OF6 4'h6
`define T1FA_SPAN_T1DM 4'hc
`define T1FA_THR_STD 4'h2
`define T1FA_THR_T1DM 4'h4
`define T1FA_HIST_LEN 12
`define T1FA_NCAND 8

`define T1FA_FMS_SF 2'h0
`define T1FA_FMS_T1DM 2'h1
`define T1FA_FMS_SLC 2'h2
`define T1FA_FDL_FULL 2'h0
`define T1FA_FDL_HALF_A 2'h1
`define T1FA_FDL_HALF_B 2'h2
`define T1FA_FDL_PHASE_A 2'h3
`define T1FA_FDL_PHASE_B 2'h1

`define T1FA_SFE_THR 3'h2
`endif

/* File: hdl/t1fa_pkg.sv */
// Purpose: Types of the T1 frame aligner control block
// Assumes: Constants come from the consts header
// Notes: Field order of the packed structs is the register bit order
`include "t1fa_consts.svh"
package t1fa_pkg;

  typedef enum logic [1:0] {FMT_SF = 2'h0, FMT_T1DM = 2'h1, FMT_SLC = 2'h2, FMT_ESF = 2'h3}
    t1fa_fmt_type;

  typedef enum logic {ALIGN_SEARCH = 1'b0, ALIGN_LOCKED = 1'b1} t1fa_align_type;

  typedef struct packed {
    logic [1:0] out_of_frame_ratio_sel;
    logic esf_search_algo_sel;
    logic esf_sel;
    logic frame_mode_sel_hi;
    logic frame_mode_sel_lo;
    logic [1:0] unused;
  } t1fa_cfg_type;

  typedef struct packed {
    logic unused;
    logic test_speedup;
    logic align_change_irq_en;
    logic framing_error_irq_en;
    logic bit_error_event_irq_en;
    logic severe_framing_irq_en;
    logic mimic_irq_en;
    logic aligned_change_irq_en;
  } t1fa_ien_type;

  typedef struct packed {
    logic align_change_flag;
    logic framing_error_flag;
    logic bit_error_event_flag;
    logic severe_framing_flag;
    logic mimic_change_flag;
    logic aligned_change_flag;
  } t1fa_evt_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic wr;
    logic rd;
  } t1fa_bus_in_type;

  typedef struct packed {
    logic fbit_strobe;
    logic fbit_error;
    logic fbit_data;
    logic [4:0] frame_num;
    logic sync_err;
    logic crc_err;
    logic sf_end;
    logic cand_valid;
    logic [`T1FA_NCAND-1:0] cand_match;
    logic [`T1FA_NCAND-1:0] cand_crc_ok;
  } t1fa_search_in_type;

  typedef struct packed {
    t1fa_cfg_type cfg;
    t1fa_ien_type ien;
    t1fa_evt_type flags;
    t1fa_align_type align;
    logic mimic;
    logic [2:0] pos;
    logic had_pos;
    logic [`T1FA_HIST_LEN-1:0] hist;
    logic [1:0] sfe_cnt;
    logic [7:0] rd_data;
    logic irq_n;
    logic fdl_bit;
    logic fdl_valid;
  } t1fa_state_type;

endpackage

/* File: testbench/t1fa_line_model.sv */
// Purpose: Line side model feeding framing bits and candidates
// Assumes: Bench hands over one command per request cycle
// Notes: Idle qualified fields toggle so stale values never look valid
`timescale 1ns/10ps
module t1fa_line_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire t1fa_pkg::t1fa_search_in_type cmd,
  output t1fa_pkg::t1fa_search_in_type search_in
);
  import t1fa_pkg::*;
  t1fa_search_in_type idle;

  always_comb
  begin
    idle = ~search_in;
    idle.fbit_strobe = 1'b0;
    idle.fbit_error = 1'b0;
    idle.sync_err = 1'b0;
    idle.crc_err = 1'b0;
    idle.sf_end = 1'b0;
    idle.cand_valid = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      search_in <= '0;
    else
      search_in <= req ? cmd : idle;
  end
endmodule // t1fa_line_model

/* File: testbench/tb.sv */
// Purpose: Self-checking bench of the frame aligner control block
// Assumes: Line model one cycle ahead of the aligner
// Notes: Random config and enables from a fixed seed
`timescale 1ns/10ps
module tb;
  import t1fa_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic req;
  t1fa_bus_in_type bus;
  t1fa_search_in_type cmd;
  t1fa_search_in_type search_in;
  logic [7:0] rd_data;
  logic irq_out_n, frame_locked_state, mimic_present, fdl_bit, fdl_valid;
  logic [7:0] ien, rv, d;
  logic [7:0] cfgs [3] = '{8'h00, 8'h48, 8'h90};
  integer seed, fail_count, tests_run, i, n;

  t1fa_frame_aligner t1fa_frame_aligner_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus_in(bus),
    .search_in(search_in), .rd_data(rd_data), .irq_out_n(irq_out_n),
    .frame_locked_state(frame_locked_state), .mimic_present(mimic_present),
    .fdl_bit(fdl_bit), .fdl_valid(fdl_valid));
  t1fa_line_model t1fa_line_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .cmd(cmd),
    .search_in(search_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic fdl_exp(input logic [1:0] m, input integer f);
    case (m)
      2'h0: return f % 2 == 1;
      2'h1: return f % 4 == 3;
      2'h2: return f % 4 == 1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic irq_exp(input logic [7:0] s);
    return ~|(s[7:2] & ien[5:0]);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wr_data <= v;
    bus.wr <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  task automatic wien(input logic [7:0] v);
    ien = v;
    wr(8'h21, v);
  endtask

  task automatic sts(input logic [7:0] exp);
    chk({7'h0, irq_out_n}, {7'h0, irq_exp(exp)});
    chk({6'h0, mimic_present, frame_locked_state}, {6'h0, exp[1:0]});
    rd(8'h22, exp);
  endtask

  task automatic lk(input logic exp);
    chk({7'h0, frame_locked_state}, {7'h0, exp});
  endtask

  task automatic pulse(input t1fa_search_in_type c);
    @(posedge sys_clk);
    req <= 1'b1;
    cmd <= c;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic fb(input logic e, input logic v, input logic [4:0] f);
    t1fa_search_in_type c;
    c = '0;
    c.fbit_strobe = 1'b1;
    c.fbit_error = e;
    c.fbit_data = v;
    c.frame_num = f;
    pulse(c);
  endtask

  task automatic cand(input logic [7:0] m, input logic [7:0] k);
    t1fa_search_in_type c;
    c = '0;
    c.cand_valid = 1'b1;
    c.cand_match = m;
    c.cand_crc_ok = k;
    pulse(c);
  endtask

  task automatic side(input integer w);
    t1fa_search_in_type c;
    c = '0;
    c.sync_err = (w == 0);
    c.crc_err = (w == 1);
    c.sf_end = (w == 2);
    pulse(c);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count = fail_count + 1;
    tally_and_finish();
  end

  initial
  begin
    seed = 32698;
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    req = 1'b0;
    bus = '0;
    cmd = '0;
    ien = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    sts(8'h00);
    rd(8'h23, 8'h00);
    for (i = 0; i < 6; i++)
    begin
      rv = $random(seed);
      rv[7:6] = rv[7:6] % 3;
      if (rv[4] && rv[3:2] == 2'h3)
        rv[3:2] = 2'h0;
      wr(8'h20, rv);
      rd(8'h20, rv & 8'hfc);
      d = $random(seed) & 8'hbf;
      wien(d);
      rd(8'h21, d & 8'h7f);
    end
    $display("registers done");
    for (i = 0; i < 3; i++)
    begin
      n = 4 + i;
      wr(8'h20, cfgs[i]);
      wien($random(seed) & 8'h3f);
      cand(8'h04, 8'h00);
      sts(8'h05);
      side(2);
      fb(1'b1, 1'b0, 5'h01);
      repeat (n - 1) fb(1'b0, 1'b1, 5'h03);
      fb(1'b1, 1'b0, 5'h05);
      lk(1'b1);
      fb(1'b1, 1'b0, 5'h07);
      lk(1'b0);
      sts(i == 2 ? 8'h54 : 8'h74);
    end
    $display("loss ratios done");
    wien(8'h3f);
    wr(8'h20, 8'h10);
    cand(8'h24, 8'h00);
    sts(8'h0a);
    cand(8'h20, 8'h00);
    sts(8'h8d);
    side(1);
    sts(8'h21);
    for (i = 0; i < 3; i++)
    begin
      wr(8'h20, {4'h1, i[1:0], 2'h0});
      for (n = 1; n <= 24; n++)
      begin
        d[0] = $random(seed);
        fb(1'b0, d[0], n[4:0]);
        chk({7'h0, fdl_valid}, {7'h0, fdl_exp(i[1:0], n)});
        if (fdl_valid === 1'b1)
          chk({7'h0, fdl_bit}, {7'h0, d[0]});
      end
    end
    $display("data link done");
    wr(8'h20, 8'h30);
    side(2);
    fb(1'b1, 1'b0, 5'h02);
    fb(1'b1, 1'b0, 5'h04);
    lk(1'b0);
    sts(8'h54);
    cand(8'h24, 8'h05);
    sts(8'h8f);
    side(2);
    fb(1'b1, 1'b0, 5'h02);
    fb(1'b1, 1'b0, 5'h04);
    sts(8'h56);
    for (i = 0; i < 2; i++)
    begin
      wr(8'h20, i ? 8'h0c : 8'h04);
      cand(8'h04, 8'h00);
      sts(i ? 8'h05 : 8'h0d);
      side(2);
      side(0);
      side(0);
      sts(8'h31);
      side(2);
      repeat (3) fb(1'b1, 1'b0, 5'h06);
      lk(1'b1);
      fb(1'b1, 1'b0, 5'h0c);
      lk(1'b0);
      sts(8'h74);
    end
    $display("t1dm done");
    wr(8'h20, 8'h00);
    cand(8'h04, 8'h00);
    sts(8'h05);
    side(1);
    sts(8'h01);
    wr(8'h23, 8'hff);
    rd(8'h20, 8'h00);
    wien(8'h00);
    fb(1'b1, 1'b0, 5'h01);
    sts(8'h61);
    $display("masking done");
    tally_and_finish();
  end
endmodule // tb
